// ### dual_interval_timer_defs.svh
// Offsets, field positions, reset values and mode codes of the dual interval timer.
// Assumes a 12-bit byte address on the register port, one 32-bit word per register.
`ifndef DUAL_INTERVAL_TIMER_DEFS_SVH
`define DUAL_INTERVAL_TIMER_DEFS_SVH

`define ADDR_W            12
`define DATA_W            32
`define CNT_W             16
`define NUM_CMP           6
`define UNIT0_NUM_CMP     3'h6
`define UNIT1_NUM_CMP     3'h5

// Global registers
`define CONFIG_OFS        12'h000
`define ENABLE_OFS        12'h004

// Unit pages: unit 0 at 0x100, unit 1 at 0x200
`define UNIT_PAGE_MSB     11
`define UNIT_PAGE_LSB     8
`define UNIT0_PAGE        4'h1
`define UNIT1_PAGE        4'h2

// Offsets inside a unit page
`define RUN_OFS           8'h00
`define CONTROL_OFS       8'h04
`define MODE_OFS          8'h08
`define BUFCTL_OFS        8'h0c
`define COUNT_OFS         8'h10
`define HOLD_BASE         8'h20
`define CMP_BASE          8'h40
`define SLOT_SPAN         8'h18

// Fields of a register address and of a slot offset
`define OFS_MSB           7
`define OFS_LSB           0
`define SLOT_MSB          4
`define SLOT_LSB          2
`define ALIGN_MSB         1
`define ALIGN_LSB         0

// Field positions
`define MODE_MSB          2
`define MODE_LSB          0
`define RUN_BIT           0
`define BUF_EN_BIT        0
`define ISEL_MSB          2
`define ISEL_LSB          1
`define CLEAR_EN_BIT      0
`define SHIFT_BIT         0
`define UNIT0_CLK_BIT     0
`define UNIT1_CLK_BIT     1

// Counter limits
`define COUNT_ZERO        16'h0000
`define COUNT_MAX         16'hffff

// Mode field codes
`define MODE_TIMER        3'h0
`define MODE_TIMER_IL     3'h1
`define MODE_PPG          3'h2
`define MODE_PPG_IL       3'h3

// First interrupt source select codes
`define ISEL_NONE         2'h0
`define ISEL_CMP0         2'h1
`define ISEL_CMP5         2'h2
`define ISEL_OVF          2'h3

`define PHASE_CMP_IDX     5
`define RESET_WORD        32'h0000_0000

`endif

// ### dual_interval_timer_pkg.sv
// Types shared by the dual interval timer: per-unit state and the whole block state.
// Field widths follow the constants in dual_interval_timer_defs.svh.
`include "dual_interval_timer_defs.svh"

package dual_interval_timer_pkg;

   typedef logic [`CNT_W-1:0]  count_t;
   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`ADDR_W-1:0] addr_t;

   typedef struct packed {
      logic                      run_bit;
      logic                      clear_enable;
      logic                      buffer_enable;
      logic [1:0]                irq0_select;
      logic                      shift_pending;
      logic                      active;
      count_t                    count;
      logic [`NUM_CMP-1:0][`CNT_W-1:0] holding;
      logic [`NUM_CMP-1:0][`CNT_W-1:0] compare;
      logic [4:0]                irq;
   } unit_state_t;

   typedef struct packed {
      logic [2:0]                unit_mode_select;
      logic [1:0]                unit_clock_enable;
      logic                      phase_go;
      unit_state_t [1:0]         unit;
      word_t                     rdata;
   } timer_state_t;

endpackage : dual_interval_timer_pkg

// ### dual_interval_timer.sv
// Pair of 16-bit up-counting interval timer units with comparators and holding registers.
// Assumes timer_tick is a one-cycle enable pulse from the external clock gear divider,
// synchronous to clk; software follows the documented set-up order.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "dual_interval_timer_defs.svh"

module dual_interval_timer
   import dual_interval_timer_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         timer_tick,
   input  wire dual_interval_timer_pkg::addr_t addr,
   input  wire dual_interval_timer_pkg::word_t wdata,
   input  wire logic                         wr,
   input  wire logic                         rd,
   output      dual_interval_timer_pkg::word_t rdata,
   output      logic [4:0]                   unit0_irq,
   output      logic [4:0]                   unit1_irq
);
   import dual_interval_timer_pkg::*;

   timer_state_t s;
   timer_state_t next_s;

   // Slot number of a holding or compare register within a unit page
   function automatic logic [2:0] slot_of
   (
      input logic [7:0] offs,
      input logic [7:0] base
   );
      logic [7:0] diff;
      begin
         diff    = offs - base;
         slot_of = diff[`SLOT_MSB:`SLOT_LSB];
      end
   endfunction : slot_of

   // True when offs addresses a valid slot of the given base for this unit
   function automatic logic slot_hit
   (
      input logic [7:0] offs,
      input logic [7:0] base,
      input logic [2:0] ncmp
   );
      logic [7:0] diff;
      begin
         diff     = offs - base;
         slot_hit = (offs >= base) && (offs < base + `SLOT_SPAN) &&
                    (diff[`ALIGN_MSB:`ALIGN_LSB] == 2'h0) &&
                    (diff[`SLOT_MSB:`SLOT_LSB] < ncmp);
      end
   endfunction : slot_hit

   // Comparator count of a unit
   function automatic logic [2:0] ncmp_of
   (
      input logic idx
   );
      begin
         ncmp_of = idx ? `UNIT1_NUM_CMP : `UNIT0_NUM_CMP;
      end
   endfunction : ncmp_of

   // Either unit page; the two global registers sit below them
   function automatic logic in_unit_page
   (
      input addr_t a
   );
      logic [3:0] page;
      begin
         page         = a[`UNIT_PAGE_MSB:`UNIT_PAGE_LSB];
         in_unit_page = (page == `UNIT0_PAGE) || (page == `UNIT1_PAGE);
      end
   endfunction : in_unit_page

   // Unit index of an address; anything but the unit 1 page maps to unit 0
   function automatic logic unit_of
   (
      input addr_t a
   );
      begin
         unit_of = (a[`UNIT_PAGE_MSB:`UNIT_PAGE_LSB] == `UNIT1_PAGE);
      end
   endfunction : unit_of

   // Modes whose counters both run from unit 0's run bit
   function automatic logic mode_is_interlock
   (
      input logic [2:0] mode
   );
      begin
         mode_is_interlock = (mode == `MODE_TIMER_IL) || (mode == `MODE_PPG_IL);
      end
   endfunction : mode_is_interlock

   // Pulse modes; codes outside the four known ones behave as plain timer
   function automatic logic mode_is_pulse
   (
      input logic [2:0] mode
   );
      begin
         mode_is_pulse = (mode == `MODE_PPG) || (mode == `MODE_PPG_IL);
      end
   endfunction : mode_is_pulse

   // First interrupt source; select 10 names compare 5, which only unit 0 has
   function automatic logic irq0_of
   (
      input logic [1:0] sel,
      input logic       unit1,
      input logic       cmp0_hit,
      input logic       cmp5_hit,
      input logic       ovf_hit
   );
      begin
         case (sel)
            `ISEL_CMP0: irq0_of = cmp0_hit;
            `ISEL_CMP5: irq0_of = !unit1 && cmp5_hit;
            `ISEL_OVF:  irq0_of = ovf_hit;
            default:    irq0_of = 1'b0;
         endcase
      end
   endfunction : irq0_of

   // Read mux; unmapped and reserved bits read as zero
   function automatic word_t read_word
   (
      input timer_state_t st,
      input addr_t        a
   );
      logic [7:0]  offs;
      logic        idx;
      unit_state_t u;
      begin
         read_word = `RESET_WORD;
         offs      = a[`OFS_MSB:`OFS_LSB];
         idx       = unit_of(a);
         u         = st.unit[idx];
         if (a == `CONFIG_OFS)
         begin
            read_word[`MODE_MSB:`MODE_LSB] = st.unit_mode_select;
         end
         else if (a == `ENABLE_OFS)
         begin
            read_word[`UNIT1_CLK_BIT:`UNIT0_CLK_BIT] = st.unit_clock_enable;
         end
         else if (in_unit_page(a))
         begin
            if (offs == `RUN_OFS)
            begin
               read_word[`RUN_BIT] = u.run_bit;
            end
            else if (offs == `CONTROL_OFS)
            begin
               read_word[`BUF_EN_BIT]          = u.buffer_enable;
               read_word[`ISEL_MSB:`ISEL_LSB]  = u.irq0_select;
            end
            else if (offs == `MODE_OFS)
            begin
               read_word[`CLEAR_EN_BIT] = u.clear_enable;
            end
            else if (offs == `COUNT_OFS)
            begin
               read_word[`CNT_W-1:0] = u.count;
            end
            else if (slot_hit(offs, `HOLD_BASE, ncmp_of(idx)))
            begin
               read_word[`CNT_W-1:0] = u.holding[slot_of(offs, `HOLD_BASE)];
            end
            else if (slot_hit(offs, `CMP_BASE, ncmp_of(idx)))
            begin
               read_word[`CNT_W-1:0] = u.compare[slot_of(offs, `CMP_BASE)];
            end
         end
      end
   endfunction : read_word

   logic [1:0]  go;
   logic        interlock;
   logic [1:0]  tick;
   logic [1:0][`NUM_CMP-1:0] match;
   logic [1:0]  overflow;
   logic [1:0]  wrap;
   logic [1:0]  ovf_allowed;
   logic [1:0]  cmp0_allowed;
   logic        pulse_mode;
   logic [7:0]  woffs;
   logic        widx;
   logic        wunit;

   always_comb
   begin
      next_s = s;
      // Mode decode from shared config field
      interlock  = mode_is_interlock(s.unit_mode_select);
      pulse_mode = mode_is_pulse(s.unit_mode_select);

      // Unit 0 run drives unit 0, and unit 1 too in the interlocked modes
      go[0] = s.unit[0].run_bit;
      // Unit 1 run ignored when interlocked
      if (s.unit_mode_select == `MODE_PPG_IL)
      begin
         // Unit 1 held back by phase width
         go[1] = s.unit[0].run_bit && s.phase_go;
      end
      else if (interlock)
      begin
         go[1] = s.unit[0].run_bit;
      end
      else
      begin
         go[1] = s.unit[1].run_bit;
      end

      // Overflow and unit 1 cmp0 suppression
      ovf_allowed[0]  = !pulse_mode;
      ovf_allowed[1]  = !pulse_mode;
      cmp0_allowed[0] = 1'b1;
      cmp0_allowed[1] = (s.unit_mode_select != `MODE_PPG_IL);

      for (int u = 0; u < 2; u++)
      begin
         tick[u]     = timer_tick && s.unit_clock_enable[u] && go[u] && s.unit[u].active;
         // Five comparators on unit 1, six on unit 0
         for (int m = 0; m < `NUM_CMP; m++)
         begin
            match[u][m] = tick[u] && (m < int'(ncmp_of(u[0]))) &&
                          (s.unit[u].count == s.unit[u].compare[m]);
         end
         overflow[u] = tick[u] && (s.unit[u].count == `COUNT_MAX);
         wrap[u]     = overflow[u] || (s.unit[u].clear_enable && match[u][0]);

         next_s.unit[u].irq    = '0;
         next_s.unit[u].active = go[u];
         if (go[u] && !s.unit[u].active)
         begin
            next_s.unit[u].count = `COUNT_ZERO;
         end
         else if (tick[u])
         begin
            if (s.unit[u].clear_enable && match[u][0])
            begin
               next_s.unit[u].count = `COUNT_ZERO;
            end
            else
            begin
               next_s.unit[u].count = s.unit[u].count + `CNT_W'(1);
            end
         end

         // Fixed sources for irq 1 to 4
         next_s.unit[u].irq[4:1] = match[u][4:1];
         next_s.unit[u].irq[0] = irq0_of(s.unit[u].irq0_select, u[0],
                                         match[u][0] && cmp0_allowed[u],
                                         match[u][`PHASE_CMP_IDX],
                                         overflow[u] && ovf_allowed[u]);

         // Buffered transfer at period end, or at once when stopped
         if (s.unit[u].shift_pending && (wrap[u] || !go[u]))
         begin
            next_s.unit[u].compare       = s.unit[u].holding;
            next_s.unit[u].shift_pending = 1'b0;
         end
      end

      // Phase shift only in interlocked pulse mode
      if (!s.unit[0].run_bit || (s.unit_mode_select != `MODE_PPG_IL))
      begin
         next_s.phase_go = 1'b0;
      end
      else if (match[0][`PHASE_CMP_IDX])
      begin
         next_s.phase_go = 1'b1;
      end

      // Register writes come last so a request set in the update cycle is kept
      woffs = addr[`OFS_MSB:`OFS_LSB];
      widx  = unit_of(addr);
      wunit = in_unit_page(addr);
      if (wr)
      begin
         if (addr == `CONFIG_OFS)
         begin
            next_s.unit_mode_select = wdata[`MODE_MSB:`MODE_LSB];
         end
         else if (addr == `ENABLE_OFS)
         begin
            next_s.unit_clock_enable[0] = wdata[`UNIT0_CLK_BIT];
            next_s.unit_clock_enable[1] = wdata[`UNIT1_CLK_BIT];
         end
         else if (wunit)
         begin
            if (woffs == `RUN_OFS)
            begin
               next_s.unit[widx].run_bit = wdata[`RUN_BIT];
            end
            else if (woffs == `CONTROL_OFS)
            begin
               next_s.unit[widx].buffer_enable = wdata[`BUF_EN_BIT];
               next_s.unit[widx].irq0_select   = wdata[`ISEL_MSB:`ISEL_LSB];
            end
            else if (woffs == `MODE_OFS)
            begin
               next_s.unit[widx].clear_enable = wdata[`CLEAR_EN_BIT];
            end
            else if (woffs == `BUFCTL_OFS)
            begin
               // Shift request wins over a transfer in the same cycle
               if (wdata[`SHIFT_BIT])
               begin
                  next_s.unit[widx].shift_pending = 1'b1;
               end
            end
            else if (slot_hit(woffs, `HOLD_BASE, ncmp_of(widx)))
            begin
               next_s.unit[widx].holding[slot_of(woffs, `HOLD_BASE)] = wdata[`CNT_W-1:0];
               if (!s.unit[widx].buffer_enable)
               begin
                  next_s.unit[widx].compare[slot_of(woffs, `HOLD_BASE)] =
                     wdata[`CNT_W-1:0];
               end
            end
         end
      end

      // Read data stands only in the cycle after the strobe
      if (rd)
      begin
         next_s.rdata = read_word(s, addr);
      end
      else
      begin
         next_s.rdata = `RESET_WORD;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign rdata     = s.rdata;
   assign unit0_irq = s.unit[0].irq;
   assign unit1_irq = s.unit[1].irq;

endmodule : dual_interval_timer

// ### dual_interval_timer_asserts.sv
// Port checker of the dual interval timer, bound into the top module.
// Shadows config and select writes; assumes units are set up while stopped.
`timescale 1ns/10ps

module dual_interval_timer_asserts
   import dual_interval_timer_pkg::*;
(
   input wire logic                           clk,
   input wire logic                           rst,
   input wire logic                           timer_tick,
   input wire dual_interval_timer_pkg::addr_t addr,
   input wire dual_interval_timer_pkg::word_t wdata,
   input wire logic                           wr,
   input wire logic                           rd,
   input wire dual_interval_timer_pkg::word_t rdata,
   input wire logic [4:0]                     unit0_irq,
   input wire logic [4:0]                     unit1_irq
);
   logic [2:0] mode_sh;
   logic [1:0] sel0;
   logic [1:0] sel1;
   logic       buf0;
   logic       pulse;
   logic [15:0] wlow;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_sh <= 3'h0;
         sel0    <= 2'h0;
         sel1    <= 2'h0;
         buf0    <= 1'b0;
      end
      else if (wr && addr == 12'h000)
         mode_sh <= wdata[2:0];
      else if (wr && addr == 12'h104)
      begin
         sel0 <= wdata[2:1];
         buf0 <= wdata[0];
      end
      else if (wr && addr == 12'h204)
         sel1 <= wdata[2:1];
   end

   assign pulse = (mode_sh == 3'h2) || (mode_sh == 3'h3);
   // Only the low half lands in a compare register
   assign wlow  = wdata[15:0];

   sequence s_direct_write;
      wr && addr == 12'h134 && !buf0 ##2 rd && addr == 12'h154;
   endsequence

   property p_rdata_idle;
      !rd |=> rdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read");
   property p_upper_zero;
      rd |=> rdata[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper half of read data not zero");
   property p_cfg_read;
      rd && addr == 12'h000 |=> rdata == {29'h0, $past(mode_sh)};
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("mode field read back wrong");
   property p_direct;
      s_direct_write |=> rdata == {16'h0, $past(wlow, 3)};
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct compare load wrong");
   property p_unmapped;
      rd && (addr == 12'h234 || addr == 12'h254) |=> rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("missing unit 1 slot reads nonzero");
   property p_tick0;
      unit0_irq != 5'h0 |-> $past(timer_tick);
   endproperty
   a_tick0: assert property (p_tick0)
      else $error("unit 0 event without a counting tick");
   property p_tick1;
      unit1_irq != 5'h0 |-> $past(timer_tick);
   endproperty
   a_tick1: assert property (p_tick1)
      else $error("unit 1 event without a counting tick");
   property p_ovf_drop;
      $past(pulse) && $past(sel0) == 2'h3 |-> !unit0_irq[0];
   endproperty
   a_ovf_drop: assert property (p_ovf_drop)
      else $error("overflow event in pulse mode");
   property p_sel0_none;
      $past(sel0) == 2'h0 |-> !unit0_irq[0];
   endproperty
   a_sel0_none: assert property (p_sel0_none)
      else $error("unit 0 first event with no source");
   property p_sel1_none;
      $past(sel1) == 2'h0 || $past(sel1) == 2'h2 |-> !unit1_irq[0];
   endproperty
   a_sel1_none: assert property (p_sel1_none)
      else $error("unit 1 first event with no source");

endmodule : dual_interval_timer_asserts

bind dual_interval_timer dual_interval_timer_asserts chk (.clk(clk), .rst(rst),
   .timer_tick(timer_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .unit0_irq(unit0_irq), .unit1_irq(unit1_irq));

// ### testbench.sv
// Self-checking bench of the dual interval timer over its register port.
// Drives the count tick itself; a full free-run wrap costs about 66k cycles.
`timescale 1ns/10ps

module testbench;
   import dual_interval_timer_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       timer_tick = 1'b0;
   logic       tick_on = 1'b1;
   addr_t      addr = 12'h000;
   word_t      wdata = 32'h0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   word_t      rdata;
   logic [4:0] unit0_irq;
   logic [4:0] unit1_irq;
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         cnt0 [5];
   int         cnt1 [5];
   word_t      v;
   word_t      w;

   always #12.5 clk = ~clk;
   always @(posedge clk) timer_tick <= tick_on;

   dual_interval_timer uut (.clk(clk), .rst(rst), .timer_tick(timer_tick), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .unit0_irq(unit0_irq),
      .unit1_irq(unit1_irq));

   task automatic check(input word_t seen, input word_t exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input addr_t a, input word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input addr_t a, output word_t d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic cfg(input addr_t b, input logic clr, input logic [1:0] sel, input logic be);
      wr_reg(b + 12'h008, {31'h0, clr});
      wr_reg(b + 12'h004, {29'h0, sel, be});
   endtask : cfg

   task automatic hold(input addr_t b, input int m, input word_t d);
      wr_reg(b + 12'h020 + 12'(4 * m), d);
   endtask : hold

   task automatic go(input logic r0, input logic r1);
      wr_reg(12'h100, {31'h0, r0});
      wr_reg(12'h200, {31'h0, r1});
   endtask : go

   // Counts event pulses seen over n cycles
   task automatic run_for(input int n);
      cnt0 = '{default: 0};
      cnt1 = '{default: 0};
      repeat (n)
      begin
         @(posedge clk);
         #1;
         for (int m = 0; m < 5; m++)
         begin
            cnt0[m] += int'(unit0_irq[m]);
            cnt1[m] += int'(unit1_irq[m]);
         end
      end
   endtask : run_for

   task automatic t_regs;
      rd_reg(12'h000, v);
      check(v, 32'h0);
      rd_reg(12'h154, v);
      check(v, 32'h0);
      hold(12'h100, 5, 32'h1234abcd);
      rd_reg(12'h154, v);
      check(v, 32'h0000abcd);
      wr_reg(12'h154, 32'h00005555);
      rd_reg(12'h154, v);
      check(v, 32'h0000abcd);
      hold(12'h200, 5, 32'h00007777);
      rd_reg(12'h254, v);
      check(v, 32'h0);
      hold(12'h200, 4, 32'h00004444);
      rd_reg(12'h250, v);
      check(v, 32'h00004444);
      $display("test regs done");
   endtask : t_regs

   task automatic t_freerun;
      wr_reg(12'h004, 32'h3);
      cfg(12'h100, 1'b0, 2'h3, 1'b0);
      go(1'b1, 1'b0);
      for (int i = 0; i < 70000 && unit0_irq[0] !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      check(word_t'(unit0_irq[0]), 32'h1);
      rd_reg(12'h110, v);
      check(v, 32'h1);
      wr_reg(12'h100, 32'h0);
      rd_reg(12'h110, v);
      rd_reg(12'h110, w);
      check(w, v);
      wr_reg(12'h100, 32'h1);
      rd_reg(12'h110, v);
      check(v, 32'h0);
      $display("test freerun done");
   endtask : t_freerun

   task automatic t_period;
      wr_reg(12'h100, 32'h0);
      cfg(12'h200, 1'b1, 2'h1, 1'b0);
      hold(12'h200, 0, 32'h9);
      for (int m = 1; m < 5; m++)
         hold(12'h200, m, word_t'(m));
      wr_reg(12'h200, 32'h1);
      run_for(5);
      run_for(30);
      for (int m = 0; m < 5; m++)
      begin
         check(word_t'(cnt1[m]), 32'h3);
         check(word_t'(cnt0[m]), 32'h0);
      end
      // Gear tick held low: counter and events stand still
      tick_on <= 1'b0;
      rd_reg(12'h210, v);
      run_for(12);
      rd_reg(12'h210, w);
      check(w, v);
      check(word_t'(cnt1[0]), 32'h0);
      tick_on <= 1'b1;
      $display("test period done");
   endtask : t_period

   task automatic t_select;
      hold(12'h100, 0, 32'h9);
      hold(12'h100, 5, 32'h5);
      for (int s = 0; s < 4; s++)
      begin
         go(1'b0, 1'b0);
         cfg(12'h100, 1'b1, 2'(s), 1'b0);
         cfg(12'h200, 1'b1, 2'(s), 1'b0);
         go(1'b1, 1'b1);
         run_for(5);
         run_for(30);
         check(word_t'(cnt0[0]), (s == 1 || s == 2) ? 32'h3 : 32'h0);
         check(word_t'(cnt1[0]), (s == 1) ? 32'h3 : 32'h0);
      end
      $display("test select done");
   endtask : t_select

   task automatic t_buffered;
      wr_reg(12'h100, 32'h0);
      cfg(12'h100, 1'b1, 2'h1, 1'b1);
      wr_reg(12'h100, 32'h1);
      hold(12'h100, 5, 32'h7);
      rd_reg(12'h154, v);
      check(v, 32'h5);
      wr_reg(12'h10c, 32'h1);
      run_for(15);
      rd_reg(12'h154, v);
      check(v, 32'h7);
      $display("test buffered done");
   endtask : t_buffered

   task automatic t_interlock;
      go(1'b0, 1'b0);
      wr_reg(12'h000, 32'h1);
      cfg(12'h200, 1'b1, 2'h1, 1'b0);
      hold(12'h200, 0, 32'h13);
      hold(12'h200, 2, 32'h9);
      wr_reg(12'h100, 32'h1);
      for (int i = 0; i < 40 && unit0_irq[0] !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      check(word_t'(unit1_irq[2]), 32'h1);
      run_for(40);
      check(word_t'(cnt0[0]), 32'h4);
      check(word_t'(cnt1[0]), 32'h2);
      wr_reg(12'h200, 32'h1);
      wr_reg(12'h200, 32'h0);
      run_for(40);
      check(word_t'(cnt1[0]), 32'h2);
      wr_reg(12'h100, 32'h0);
      run_for(40);
      check(word_t'(cnt1[0]), 32'h0);
      $display("test interlock done");
   endtask : t_interlock

   task automatic t_pulse;
      wr_reg(12'h000, 32'h3);
      cfg(12'h100, 1'b1, 2'h3, 1'b1);
      wr_reg(12'h100, 32'h1);
      run_for(30);
      // Unit 1 is released one tick after compare 5 matches and counts its first tick one tick later
      rd_reg(12'h210, v);
      check(v, 32'h1);
      run_for(40);
      check(word_t'(cnt1[0]), 32'h0);
      check(word_t'(cnt0[0]), 32'h0);
      check(word_t'(cnt1[2]), 32'h2);
      $display("test pulse done");
   endtask : t_pulse

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_freerun();
      t_period();
      t_select();
      t_buffered();
      t_interlock();
      t_pulse();
      test_done();
   end

   // Full wrap plus all short tests stays well below this
   initial
   begin
      #2500000;
      n_mismatch++;
      test_done();
   end

endmodule : testbench
